// *** src/command_status_register.sv ***
// command and status register of the open host controller core
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module command_status_register
  import cmd_status_pkg::*;
#(
  parameter int RESET_CYCLES = SW_RESET_CYCLES
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // frame and list engines
  input  wire logic        overrun_i,
  input  wire logic        ctrl_head_i,
  input  wire logic        ctrl_td_found_i,
  input  wire logic        bulk_head_i,
  input  wire logic        bulk_td_found_i,
  input  wire logic        ownership_done_i,
  output logic             ctrl_process_o,
  output logic             bulk_process_o,
  // interrupt status neighbours
  output logic             overrun_event_o,
  output logic             ownership_event_o,
  // software reset sequencing
  output logic             sw_reset_active_o,
  output logic             enter_suspend_o,
  output logic             host_bus_allowed_o,
  output logic             root_hub_reset_o
);
  typedef struct packed {
    logic                 sw_reset;
    logic                 ctrl_filled;
    logic                 bulk_filled;
    logic                 own_req;
    logic [OVR_CNT_W-1:0] ovr_cnt;
    logic                 ovr_evt;
    logic                 own_evt;
    logic                 ctrl_go;
    logic                 bulk_go;
    logic [31:0]          rdata;
  } regs_s;

  regs_s st;
  regs_s next_st;
  logic  hit;
  logic  set_req;
  logic  timer_busy;
  logic  timer_done;
  logic [31:0] cur;

  sw_reset_timer #(
    .RESET_CYCLES(RESET_CYCLES)
  ) u_timer (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .start_i(set_req),
    .busy_o (timer_busy),
    .done_o (timer_done)
  );

  assign hit = addr_i == CMD_STATUS_OFFSET;

  always_comb begin
    cur = CMD_STATUS_RESET;
    cur[RESET_BIT_POS]   = st.sw_reset;
    cur[CTRL_FILLED_POS] = st.ctrl_filled;
    cur[BULK_FILLED_POS] = st.bulk_filled;
    cur[OWN_REQ_POS]     = st.own_req;
    cur[OVR_CNT_LSB +: OVR_CNT_W] = st.ovr_cnt;
  end

  // start timer only on a fresh request, not a rewrite during a running reset;
  // a request landing on the completion cycle restarts it, else the bit would stick
  assign set_req = wr_i && hit && wdata_i[RESET_BIT_POS] && (!st.sw_reset || timer_done);

  always_comb begin
    next_st         = st;
    next_st.ovr_evt = 1'b0;
    next_st.own_evt = 1'b0;
    next_st.ctrl_go = 1'b0;
    next_st.bulk_go = 1'b0;
    next_st.rdata   = UNMAPPED_READ;
    // engine side first, so a software set in the same cycle wins
    if (ctrl_head_i) begin
      next_st.ctrl_filled = 1'b0;
      next_st.ctrl_go     = st.ctrl_filled;
    end
    if (ctrl_td_found_i) next_st.ctrl_filled = 1'b1;
    if (bulk_head_i) begin
      next_st.bulk_filled = 1'b0;
      next_st.bulk_go     = st.bulk_filled;
    end
    if (bulk_td_found_i) next_st.bulk_filled = 1'b1;
    if (ownership_done_i) next_st.own_req = 1'b0;
    if (overrun_i) begin
      next_st.ovr_cnt = st.ovr_cnt + OVR_CNT_W'(1);
      next_st.ovr_evt = 1'b1;
    end
    if (timer_done) next_st.sw_reset = 1'b0;
    if (wr_i && hit) begin
      // write-to-set; reserved bits ignored (software keeps them zero)
      if (wdata_i[RESET_BIT_POS])   next_st.sw_reset = 1'b1;
      if (wdata_i[CTRL_FILLED_POS]) next_st.ctrl_filled = 1'b1;
      if (wdata_i[BULK_FILLED_POS]) next_st.bulk_filled = 1'b1;
      if (wdata_i[OWN_REQ_POS]) begin
        next_st.own_req = 1'b1;
        next_st.own_evt = 1'b1;
      end
    end
    if (rd_i && hit) next_st.rdata = cur;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) st <= '0;
    else       st <= next_st;
  end

  assign rdata_o            = st.rdata;
  assign ctrl_process_o     = st.ctrl_go;
  assign bulk_process_o     = st.bulk_go;
  // enable and master gating of this flag live in the interrupt block
  assign overrun_event_o    = st.ovr_evt;
  assign ownership_event_o  = st.own_evt;
  assign sw_reset_active_o  = st.sw_reset;
  assign enter_suspend_o    = set_req;
  assign host_bus_allowed_o = !st.sw_reset && !timer_busy;
  assign root_hub_reset_o   = 1'b0;

  write_sets_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_i && hit && wdata_i[CTRL_FILLED_POS] |=> st.ctrl_filled)
    else $error("written one did not set control filled");
  zero_keeps_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_i && hit && !wdata_i[OWN_REQ_POS] && !ownership_done_i |=> st.own_req == $past(st.own_req))
    else $error("written zero changed ownership request");
  read_value_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_i && hit |=> rdata_o == $past(cur))
    else $error("read data mismatch");
  read_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_i && !wr_i && !overrun_i && !ctrl_head_i && !bulk_head_i && !ownership_done_i && !timer_done
    && !ctrl_td_found_i && !bulk_td_found_i
    |=> cur == $past(cur))
    else $error("read disturbed register");
  overrun_count_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    overrun_i |=> overrun_event_o && st.ovr_cnt == $past(st.ovr_cnt) + 2'h1)
    else $error("overrun not counted");
  own_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_i && hit && wdata_i[OWN_REQ_POS] |=> ownership_event_o && st.own_req)
    else $error("ownership flag not raised");
  own_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ownership_done_i && !(wr_i && hit && wdata_i[OWN_REQ_POS]) |=> !st.own_req)
    else $error("ownership request not cleared");
  bulk_skip_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    bulk_head_i |=> bulk_process_o == $past(st.bulk_filled))
    else $error("bulk start decision wrong");
  ctrl_skip_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ctrl_head_i && !ctrl_td_found_i && !(wr_i && hit && wdata_i[CTRL_FILLED_POS])
    |=> !st.ctrl_filled && ctrl_process_o == $past(st.ctrl_filled))
    else $error("control start decision wrong");
  td_refill_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    bulk_td_found_i |=> st.bulk_filled)
    else $error("bulk filled not re-set");
  no_bus_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st.sw_reset |-> !host_bus_allowed_o)
    else $error("bus allowed during reset");
  reset_ends_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    set_req |=> st.sw_reset ##[1:1000] !st.sw_reset)
    else $error("reset bit not self-cleared");

  ctrl_refill_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ctrl_td_found_i |=> st.ctrl_filled)
    else $error("control filled not re-set");
  bulk_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    bulk_head_i && !bulk_td_found_i && !(wr_i && hit && wdata_i[BULK_FILLED_POS]) |=> !st.bulk_filled)
    else $error("bulk filled not cleared at list head");
  ovr_wrap_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    overrun_i && st.ovr_cnt == 2'h3 |=> st.ovr_cnt == 2'h0)
    else $error("overrun counter did not wrap");
  ovr_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !overrun_i |=> st.ovr_cnt == $past(st.ovr_cnt) && !overrun_event_o)
    else $error("overrun counter moved without overrun");
  own_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(wr_i && hit && wdata_i[OWN_REQ_POS]) |=> !ownership_event_o)
    else $error("ownership flag without request");
  suspend_start_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_i && hit && wdata_i[RESET_BIT_POS] && !st.sw_reset |-> enter_suspend_o)
    else $error("software reset did not enter suspend");
  root_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !root_hub_reset_o)
    else $error("root hub reset driven");
  bus_blocked_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    timer_busy |-> !host_bus_allowed_o)
    else $error("bus allowed while reset timer runs");
  reset_held_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st.sw_reset && !timer_done |=> st.sw_reset)
    else $error("reset bit cleared early");
  reset_restart_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_i && hit && wdata_i[RESET_BIT_POS] && timer_done |=> st.sw_reset && timer_busy)
    else $error("reset request lost at completion");
  reserved_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_i && hit |=> rdata_o[31:18] == 14'h0000 && rdata_o[15:4] == 12'h000)
    else $error("reserved bits read nonzero");
  idle_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(rd_i && hit) |=> rdata_o == UNMAPPED_READ)
    else $error("read data outside read cycle");
endmodule : command_status_register

// *** src/cmd_status_pkg.sv ***
// constants shared by the command/status register block
package cmd_status_pkg;
  localparam logic [7:0]  CMD_STATUS_OFFSET = 8'h08;
  localparam logic [31:0] CMD_STATUS_RESET  = 32'h0000_0000;
  localparam int          RESET_BIT_POS     = 0;
  localparam int          CTRL_FILLED_POS   = 1;
  localparam int          BULK_FILLED_POS   = 2;
  localparam int          OWN_REQ_POS       = 3;
  localparam int          OVR_CNT_LSB       = 16;
  localparam int          OVR_CNT_W         = 2;
  localparam logic [31:0] WRITABLE_MASK     = 32'h0000_000F;
  localparam int          CLK_MHZ           = 50;
  localparam int          SW_RESET_MAX_US   = 10;
  // longest time: round down
  localparam int          SW_RESET_CYCLES   = SW_RESET_MAX_US * CLK_MHZ;
  localparam int          SW_RESET_CNT_W    = 10;
  localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;
endpackage : cmd_status_pkg

// *** src/sw_reset_timer.sv ***
// timer that sequences a software reset and bounds its length
`timescale 1ns/1ps
module sw_reset_timer
  import cmd_status_pkg::*;
#(
  parameter int RESET_CYCLES = SW_RESET_CYCLES
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // control
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);
  initial begin
    if (RESET_CYCLES < 2 || RESET_CYCLES >= (1 << SW_RESET_CNT_W))
      $error("sw_reset_timer: RESET_CYCLES out of range");
  end

  typedef struct packed {
    logic                      busy;
    logic                      done;
    logic [SW_RESET_CNT_W-1:0] count;
  } timer_s;

  timer_s st;
  timer_s next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (st.busy) begin
      if (st.count == SW_RESET_CNT_W'(RESET_CYCLES - 1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.count = st.count + SW_RESET_CNT_W'(1);
      end
    end else if (start_i) begin
      next_st.busy  = 1'b1;
      next_st.count = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) st <= '0;
    else       st <= next_st;
  end

  assign busy_o = st.busy;
  assign done_o = st.done;

  reset_bounded_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(st.busy) |-> ##[1:1000] st.done)
    else $error("software reset ran too long");
endmodule : sw_reset_timer

// *** sim/test_host_command_status_register.sv ***
// self-checking bench for the command/status register block
`timescale 1ns/1ps
module test_host_command_status_register;
  import cmd_status_pkg::*;
  // small reset length keeps the software reset walk short
  localparam int RC = 4;
  logic        mclk_i      = 1'b0;
  logic        rst_i       = 1'b1;
  logic [7:0]  addr_i      = 8'h00;
  logic [31:0] wdata_i     = 32'h0;
  logic        wr_i        = 1'b0;
  logic        rd_i        = 1'b0;
  // engine pulses: 0 overrun, 1 ctrl head, 2 ctrl td, 3 bulk head, 4 bulk td, 5 ownership done
  logic [5:0]  eng         = 6'h00;
  logic [31:0] rdata_o;
  logic        ctrl_process_o, bulk_process_o, overrun_event_o, ownership_event_o;
  logic        sw_reset_active_o, enter_suspend_o, host_bus_allowed_o, root_hub_reset_o;
  logic [31:0] d;
  int          n_mismatch  = 0;
  int          check_count = 0;
  int          n;

  always #10 mclk_i = ~mclk_i;

  command_status_register #(.RESET_CYCLES(RC)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .overrun_i(eng[0]), .ctrl_head_i(eng[1]), .ctrl_td_found_i(eng[2]),
    .bulk_head_i(eng[3]), .bulk_td_found_i(eng[4]), .ownership_done_i(eng[5]),
    .ctrl_process_o(ctrl_process_o), .bulk_process_o(bulk_process_o),
    .overrun_event_o(overrun_event_o), .ownership_event_o(ownership_event_o),
    .sw_reset_active_o(sw_reset_active_o), .enter_suspend_o(enter_suspend_o),
    .host_bus_allowed_o(host_bus_allowed_o), .root_hub_reset_o(root_hub_reset_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd

  // settled value seen just after the edge that took the pulse
  task automatic pulse(input int b);
    @(posedge mclk_i);
    eng[b] <= 1'b1;
    @(posedge mclk_i);
    eng[b] <= 1'b0;
    #1;
  endtask : pulse

  task automatic rchk(input logic [31:0] exp);
    rd(CMD_STATUS_OFFSET, d);
    chk(d, exp);
  endtask : rchk

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic t_regs;
    rchk(32'h0);
    rd(8'h0C, d);
    chk(d, 32'h0);
    wr(CMD_STATUS_OFFSET, 32'h2);
    wr(CMD_STATUS_OFFSET, 32'h4);
    rchk(32'h6);
    rchk(32'h6);
    wr(CMD_STATUS_OFFSET, 32'h0);
    wr(8'h0C, 32'hF);
    rchk(32'h6);
    $display("test regs done");
  endtask : t_regs

  task automatic t_lists;
    pulse(3);
    chk(bulk_process_o, 1'b1);
    rchk(32'h2);
    pulse(3);
    chk(bulk_process_o, 1'b0);
    pulse(4);
    rchk(32'h6);
    pulse(1);
    chk(ctrl_process_o, 1'b1);
    rchk(32'h4);
    pulse(1);
    chk(ctrl_process_o, 1'b0);
    pulse(2);
    rchk(32'h6);
    pulse(1);
    pulse(3);
    rchk(32'h0);
    $display("test lists done");
  endtask : t_lists

  task automatic t_overrun;
    // five overruns back to back with reads between; status flag never cleared here
    for (int i = 1; i <= 5; i++) begin
      pulse(0);
      chk(overrun_event_o, 1'b1);
      rchk(32'(i % 4) << 16);
    end
    $display("test overrun done");
  endtask : t_overrun

  task automatic t_own;
    wr(CMD_STATUS_OFFSET, 32'h8);
    chk(ownership_event_o, 1'b1);
    rchk(32'h0001_0008);
    pulse(5);
    rchk(32'h0001_0000);
    rchk(32'h0001_0000);
    $display("test ownership done");
  endtask : t_own

  task automatic t_swreset;
    @(posedge mclk_i);
    addr_i  <= CMD_STATUS_OFFSET;
    wdata_i <= 32'h1;
    wr_i    <= 1'b1;
    #1;
    chk(enter_suspend_o, 1'b1);
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
    chk(sw_reset_active_o, 1'b1);
    chk(host_bus_allowed_o, 1'b0);
    chk(root_hub_reset_o, 1'b0);
    n = 1;
    while (sw_reset_active_o === 1'b1 && n < 50) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(n >= RC && n <= RC + 2, 1'b1);
    chk(host_bus_allowed_o, 1'b1);
    rd(CMD_STATUS_OFFSET, d);
    chk(d[0], 1'b0);
    $display("test software reset done");
  endtask : t_swreset

  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_regs();
    t_lists();
    t_overrun();
    t_own();
    t_swreset();
    summarize();
  end

  // whole run needs about a hundred cycles
  initial begin
    #(20 * 5000);
    n_mismatch++;
    summarize();
  end
endmodule : test_host_command_status_register
